// ==== pkg/sfc_params.svh ====
// Constants for the serial frame codec: frame layout, nibbles, map, timing
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

`define SFC_FRAME_W 24
`define SFC_FIELD_W 20
// Coding nibbles stored as frame bits 23:20, that is {C3,C2,C1,C0}
`define SFC_NIB_D0_TRUE 4'hB
`define SFC_NIB_D0_INV 4'h4
`define SFC_NIB_D1_TRUE 4'hD
`define SFC_NIB_D1_INV 4'h2
`define SFC_NIB_FILL 4'hC
`define SFC_NIB_RSV 4'h3
`define SFC_NIB_ALT_A 4'h5
`define SFC_NIB_ALT_B 4'hA
// Fill data fields, bit 0 first on the line
`define SFC_FIELD_SQUARE 20'h003FF
`define SFC_FIELD_HEAVY 20'h007FF
`define SFC_FIELD_LIGHT 20'h001FF
// Field bits 10:9 that tell fill and reserved frames apart
`define SFC_CLS_HI 10
`define SFC_CLS_LO 9
`define SFC_CLS_SQUARE 2'h1
`define SFC_CLS_HEAVY 2'h3
`define SFC_CLS_LIGHT 2'h0
`define SFC_CLS_RSV_FILL 2'h2
`define SFC_CLS_RSV_ALT 2'h1
// Positions inside the 40-bit word {field1, field0}
`define SFC_POS_F0 14
`define SFC_POS_F1 19
`define SFC_POS_P0 17
`define SFC_POS_P1 18
`define SFC_POS_P2 20
`define SFC_POS_P3 21
`define SFC_POS_M0 34
`define SFC_POS_M1 39
`define SFC_POS_LOW3 12
`define SFC_POS_F1_D 22
`define SFC_POS_F1_B7 35
// Control code values, bit one then bit zero
`define SFC_CODE_IDLE 2'h0
`define SFC_CODE_REQUEST 2'h1
`define SFC_CODE_PACKET 2'h2
`define SFC_CODE_BURST 2'h3
// Register map
`define SFC_ADDR_W 4
`define SFC_ADDR_CTRL 4'h0
`define SFC_ADDR_STATUS 4'h4
`define SFC_ADDR_BALANCE 4'h8
`define SFC_CTRL_DATA 0
`define SFC_CTRL_SQUARE 1
`define SFC_CTRL_READY 2
`define SFC_CTRL_W 3
`define SFC_ST_UNLOCK 0
`define SFC_ST_ALIGNED 1
`define SFC_ST_OFF_LO 8
// Timing
`define SFC_LINE_MULT 48
`define SFC_RX_MULT 24
`define SFC_SB_LANE_VOTE 2'h2
`define SFC_IND_PAR_CLKS 4
`define SFC_FRAMES_PER_PAR_CLK 2
`define SFC_ERR_RUN 2

`endif

// ==== pkg/sfc_pkg.sv ====
// Types shared by the serial frame codec
package sfc_pkg;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] parity;
		logic request;
		logic packet;
		logic burst;
		logic sideband_bit_zero;
		logic sideband_bit_one;
	} sfc_word_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] parity;
		logic request;
		logic packet;
		logic burst;
	} sfc_dst_t;

	typedef enum logic [2:0] {
		SFC_K_DATA,
		SFC_K_SQUARE,
		SFC_K_READY,
		SFC_K_ERROR,
		SFC_K_RESERVED
	} sfc_kind_t;

endpackage

// ==== rtl/sfc_codec.sv ====
// Serial frame codec: transmit framing with balance, receive lock and decode
// Function
// (RQ1) Frames leave bit 0 first, coding nibble last, one means light on.
// (RQ2) Running balance counts up per one sent, down per zero sent.
// (RQ3) Balance restarts when emit_fill_square falls.
// (RQ4) Data frames get nibble 1101 for half 0, 1011 for half 1.
// (RQ5) Each data frame gets its own fresh ones-minus-zeros count.
// (RQ6) Frame inverted whole when its count sign equals the balance sign.
// (RQ7) emit_fill_square sends square fill frames, balanced by themselves.
// (RQ8) emit_fill_ready sends light fill on positive balance, else heavy.
// (RQ9) Heavy has one more one than square, light one fewer, nibble 0011.
// (RQ10) Line rate is 48 times the parallel clock.
// (RQ11) Receiver frames on the edge between nibble bits one and two.
// (RQ12) Receiver samples 24 bits per nibble_edge_clock period.
// (RQ13) Each received frame except a reserved one raises exactly one seen flag.
// (RQ14) Reserved frames are dropped and never sent.
// (RQ15) Nibbles 1010, 0101, equal middle bits, bad fills are frame errors.
// (RQ16) Data nibbles un-invert the field and give half_word_select.
// (RQ17) Fill frames zero control, ready, connect and force parity error.
// (RQ18) Frame error forces parity error and holds request, packet, burst.
// (RQ19) Frame error advances sideband slot, holding last sideband values.
// (RQ20) Two frame errors in a row reset the link.
// (RQ21) Half 0 and next half 1 join into one 40-bit word.
// (RQ22) Control decoded goes out with the data of the same word.
// (RQ23) Two of three ones give a ready or connect four parallel clocks wide.
// (RQ24) Control code: idle 00, request 01, packet 10, burst 11.
`timescale 1ns/100ps
`include "sfc_params.svh"

module sfc_codec import sfc_pkg::*; #(
	parameter int BAL_W = 8
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [`SFC_ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	input wire sfc_word_t tx_word_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic tx_multiplier_unlocked_i,
	output logic [`SFC_FRAME_W-1:0] tx_frame_o,
	input wire logic [`SFC_FRAME_W-1:0] rx_bits_i,
	input wire logic rx_valid_i,
	output logic data_frame_seen_o,
	output logic square_fill_seen_o,
	output logic ready_fill_seen_o,
	output logic frame_error_seen_o,
	output logic link_reset_o,
	output sfc_dst_t dst_o,
	output logic dst_valid_o,
	output logic ready_o,
	output logic connect_o
);

	localparam int IND_CYC = `SFC_IND_PAR_CLKS * `SFC_FRAMES_PER_PAR_CLK;

	// Place of data bit k inside {field1, field0}
	function automatic logic [5:0] dpos(input int k);
		int i;
		int j;
		int p;
		i = k % 8;
		j = k / 8;
		if (i < 3)
			p = 4 * i + j;
		else if (i == 3)
			p = `SFC_POS_LOW3 + j + ((j > 1) ? 1 : 0);
		else if (i < 7)
			p = `SFC_POS_F1_D + 4 * (i - 4) + j;
		else
			p = `SFC_POS_F1_B7 + j;
		return 6'(p);
	endfunction

	function automatic logic [39:0] encode(input sfc_word_t w);
		logic [39:0] f;
		logic [1:0] code;
		f = '0;
		for (int k = 0; k < 32; k++) begin
			f[dpos(k)] = w.data[k];
		end
		if (w.request && w.packet && w.burst) // RQ24
			code = `SFC_CODE_BURST;
		else if (w.request && w.packet && !w.burst)
			code = `SFC_CODE_PACKET;
		else if (w.request && !w.packet && !w.burst)
			code = `SFC_CODE_REQUEST;
		else
			code = `SFC_CODE_IDLE;
		f[`SFC_POS_F0] = code[0];
		f[`SFC_POS_F1] = code[1];
		f[`SFC_POS_P0] = w.parity[0];
		f[`SFC_POS_P1] = w.parity[1];
		f[`SFC_POS_P2] = w.parity[2];
		f[`SFC_POS_P3] = w.parity[3];
		f[`SFC_POS_M0] = w.sideband_bit_zero;
		f[`SFC_POS_M1] = w.sideband_bit_one;
		return f;
	endfunction

	function automatic sfc_dst_t decode(input logic [39:0] f);
		sfc_dst_t d;
		logic [1:0] code;
		d = '0;
		for (int k = 0; k < 32; k++) begin
			d.data[k] = f[dpos(k)];
		end
		d.parity = {f[`SFC_POS_P3], f[`SFC_POS_P2], f[`SFC_POS_P1],
			f[`SFC_POS_P0]};
		code = {f[`SFC_POS_F1], f[`SFC_POS_F0]};
		d.request = (code != `SFC_CODE_IDLE); // RQ24
		d.packet = (code == `SFC_CODE_PACKET) || (code == `SFC_CODE_BURST);
		d.burst = (code == `SFC_CODE_BURST);
		return d;
	endfunction

	// Ones minus zeros over a frame, range -24 to 24
	function automatic logic signed [5:0] frame_disp(input logic [23:0] f);
		logic [4:0] ones;
		logic [5:0] d;
		ones = '0;
		for (int b = 0; b < `SFC_FRAME_W; b++) begin
			ones = ones + 5'(f[b]);
		end
		d = {ones, 1'b0} - 6'd24;
		return $signed(d);
	endfunction

	function automatic sfc_kind_t classify(input logic [23:0] f);
		logic [3:0] nib;
		logic [1:0] cls;
		sfc_kind_t k;
		nib = f[23:20];
		cls = f[`SFC_CLS_HI:`SFC_CLS_LO];
		if (nib[1] == nib[2]) begin // RQ15
			k = SFC_K_ERROR;
		end else begin
			case (nib)
				`SFC_NIB_D0_TRUE, `SFC_NIB_D0_INV, `SFC_NIB_D1_TRUE,
				`SFC_NIB_D1_INV: k = SFC_K_DATA; // RQ16
				`SFC_NIB_FILL: begin
					if (cls == `SFC_CLS_SQUARE)
						k = SFC_K_SQUARE;
					else if (cls == `SFC_CLS_RSV_FILL)
						k = SFC_K_RESERVED; // RQ14
					else
						k = SFC_K_READY;
				end
				`SFC_NIB_RSV: k = (cls == `SFC_CLS_RSV_ALT) ?
					SFC_K_RESERVED : SFC_K_ERROR; // RQ14 RQ15
				default: k = SFC_K_ERROR; // RQ15
			endcase
		end
		return k;
	endfunction

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	// Register file
	logic [`SFC_CTRL_W-1:0] ctrl_reg;
	logic [31:0] rdata_reg;
	logic signed [BAL_W-1:0] bal_reg;
	logic rx_aligned_reg;
	logic [4:0] rx_off_reg;

	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			ctrl_reg <= '0;
		else if (reg_we_i && reg_addr_i == `SFC_ADDR_CTRL)
			ctrl_reg <= reg_wdata_i[`SFC_CTRL_W-1:0];
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_reg <= '0;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				`SFC_ADDR_CTRL: rdata_reg <= {29'h0, ctrl_reg};
				`SFC_ADDR_STATUS: rdata_reg <= {19'h0, rx_off_reg, 6'h0,
					rx_aligned_reg, tx_multiplier_unlocked_i};
				`SFC_ADDR_BALANCE: rdata_reg <= 32'(unsigned'(bal_reg));
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end
	assign reg_rdata_o = rdata_reg;

	// Transmit
	logic prev_sq_reg;
	logic [39:0] tx_fields_reg;
	logic tx_have_reg;
	logic tx_half_reg;
	logic tx_ready_reg;
	logic [23:0] tx_frame_reg;
	logic signed [BAL_W-1:0] tx_base_reg;
	logic sq_fall;
	logic signed [BAL_W-1:0] base;
	logic signed [BAL_W-1:0] bal_next;
	logic [19:0] tx_field;
	logic [23:0] true_fr;
	logic [23:0] tx_next;
	logic signed [5:0] nd;
	logic take_half;
	logic tx_have_next;

	always_comb begin
		sq_fall = prev_sq_reg && !ctrl_reg[`SFC_CTRL_SQUARE];
		base = sq_fall ? '0 : bal_reg; // RQ3
		tx_field = tx_half_reg ? tx_fields_reg[39:20] : tx_fields_reg[19:0];
		true_fr = {tx_half_reg ? `SFC_NIB_D1_TRUE : `SFC_NIB_D0_TRUE,
			tx_field}; // RQ4
		nd = frame_disp(true_fr); // RQ5
		take_half = 1'b0;
		if (ctrl_reg[`SFC_CTRL_SQUARE]) begin
			tx_next = {`SFC_NIB_FILL, `SFC_FIELD_SQUARE}; // RQ7
		end else if (ctrl_reg[`SFC_CTRL_READY]) begin
			// RQ8 RQ9
			tx_next = {`SFC_NIB_FILL, (base > 0) ? `SFC_FIELD_LIGHT :
				`SFC_FIELD_HEAVY};
		end else if (ctrl_reg[`SFC_CTRL_DATA] && tx_have_reg) begin
			take_half = 1'b1;
			// Zero balance counts as positive
			tx_next = (nd[5] == base[BAL_W-1]) ? ~true_fr : true_fr; // RQ6
		end else begin
			// Idle line keeps the receiver locked; reserved codes never leave
			tx_next = {`SFC_NIB_FILL, `SFC_FIELD_SQUARE}; // RQ14
		end
		bal_next = base + BAL_W'(frame_disp(tx_next)); // RQ2
		if (take_half && tx_half_reg)
			tx_have_next = 1'b0;
		else if (tx_valid_i && tx_ready_reg)
			tx_have_next = 1'b1;
		else
			tx_have_next = tx_have_reg;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			prev_sq_reg <= 1'b0;
			bal_reg <= '0;
			tx_base_reg <= '0;
			tx_frame_reg <= {`SFC_NIB_FILL, `SFC_FIELD_SQUARE};
		end else begin
			prev_sq_reg <= ctrl_reg[`SFC_CTRL_SQUARE];
			bal_reg <= bal_next; // RQ2 RQ3
			tx_base_reg <= base;
			// One frame per clock; the serializer shifts bit 0 first at the
			// line multiple of the parallel clock
			tx_frame_reg <= tx_next; // RQ1 RQ10
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tx_have_reg <= 1'b0;
			tx_half_reg <= 1'b0;
			tx_ready_reg <= 1'b0;
			tx_fields_reg <= '0;
		end else begin
			tx_have_reg <= tx_have_next;
			tx_ready_reg <= !tx_have_next;
			if (take_half)
				tx_half_reg <= !tx_half_reg;
			if (tx_valid_i && tx_ready_reg)
				tx_fields_reg <= encode(tx_word_i);
		end
	end
	assign tx_ready_o = tx_ready_reg;
	assign tx_frame_o = tx_frame_reg;

	// Receive alignment and classification
	logic [23:0] rx_prev_reg;
	logic [47:0] win;
	logic [23:0] rx_fr;
	logic [3:0] rx_nib;
	sfc_kind_t rx_kind;
	logic rx_inv;
	logic rx_half;
	logic [19:0] rx_field;
	logic err_prev_reg;
	logic [3:0] seen_reg;
	logic link_reset_reg;
	logic rx_primed_reg;

	always_comb begin
		win = {rx_bits_i, rx_prev_reg};
		rx_fr = win[rx_off_reg +: `SFC_FRAME_W]; // RQ11
		rx_nib = rx_fr[23:20];
		// Before the first chunk the window holds no frame; a false error
		// here would start an error run out of reset
		rx_kind = rx_primed_reg ? classify(rx_fr) : SFC_K_RESERVED; // RQ14
		rx_inv = (rx_nib == `SFC_NIB_D0_INV) || (rx_nib == `SFC_NIB_D1_INV);
		rx_half = (rx_nib == `SFC_NIB_D1_TRUE) || (rx_nib == `SFC_NIB_D1_INV);
		rx_field = rx_inv ? ~rx_fr[19:0] : rx_fr[19:0]; // RQ16
	end

	// A single bit error must not throw away lock, so slip only on a run
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rx_prev_reg <= '0;
			rx_primed_reg <= 1'b0;
			rx_off_reg <= '0;
			rx_aligned_reg <= 1'b0;
			err_prev_reg <= 1'b0;
			link_reset_reg <= 1'b0;
			seen_reg <= '0;
		end else begin
			link_reset_reg <= 1'b0;
			seen_reg <= '0;
			if (rx_valid_i) begin
				rx_prev_reg <= rx_bits_i;
				rx_primed_reg <= 1'b1;
				// Bit sampling at 24 per edge clock happens in the deserializer
				rx_aligned_reg <= rx_nib[1] != rx_nib[2]; // RQ11 RQ12
				seen_reg <= {rx_kind == SFC_K_ERROR, rx_kind == SFC_K_READY,
					rx_kind == SFC_K_SQUARE, rx_kind == SFC_K_DATA}; // RQ13
				if (rx_kind == SFC_K_ERROR) begin
					err_prev_reg <= 1'b1;
					if (err_prev_reg) begin
						link_reset_reg <= 1'b1; // RQ20
						if (rx_nib[1] == rx_nib[2])
							rx_off_reg <= (rx_off_reg == 5'd23) ? '0 :
								rx_off_reg + 5'd1; // RQ11
					end
				end else if (rx_kind != SFC_K_RESERVED) begin
					err_prev_reg <= 1'b0;
				end
			end
		end
	end
	assign {frame_error_seen_o, ready_fill_seen_o, square_fill_seen_o,
		data_frame_seen_o} = seen_reg;
	assign link_reset_o = link_reset_reg;

	// Word pairing and destination side
	logic [19:0] pend_reg;
	logic pend_v_reg;
	sfc_dst_t dst_reg;
	logic dst_valid_reg;
	logic word_done;
	sfc_dst_t word_dec;

	always_comb begin
		word_done = rx_valid_i && rx_kind == SFC_K_DATA && rx_half &&
			pend_v_reg; // RQ21
		word_dec = decode({rx_field, pend_reg});
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pend_reg <= '0;
			pend_v_reg <= 1'b0;
			dst_reg <= '0;
			dst_valid_reg <= 1'b0;
		end else begin
			dst_valid_reg <= 1'b0;
			if (rx_valid_i) begin
				unique case (rx_kind)
					SFC_K_DATA: begin
						pend_v_reg <= !rx_half; // RQ21
						if (!rx_half)
							pend_reg <= rx_field;
						if (word_done) begin
							dst_reg <= word_dec; // RQ22
							dst_valid_reg <= 1'b1;
						end
					end
					SFC_K_SQUARE, SFC_K_READY: begin
						pend_v_reg <= 1'b0;
						dst_reg <= '0; // RQ17
						dst_valid_reg <= 1'b1;
					end
					SFC_K_ERROR: begin
						pend_v_reg <= 1'b0;
						dst_reg.data <= '0; // RQ18
						dst_reg.parity <= '0;
						dst_valid_reg <= 1'b1;
					end
					SFC_K_RESERVED: begin
					end
				endcase
			end
		end
	end
	assign dst_o = dst_reg;
	assign dst_valid_o = dst_valid_reg;

	// Sideband slots; channel 0 is ready, channel 1 is connect
	logic [3:0] slot_reg;
	logic [1:0] sb_last_reg;
	logic [1:0] vote0_reg;
	logic [1:0] vote1_reg;
	logic [3:0] ind_cnt_reg [2];
	logic [1:0] ind_reg;
	logic sb_step;
	logic is_fill;
	logic [1:0] sb_now;

	always_comb begin
		is_fill = rx_valid_i &&
			(rx_kind == SFC_K_SQUARE || rx_kind == SFC_K_READY);
		sb_step = word_done || (rx_valid_i && rx_kind == SFC_K_ERROR);
		sb_now = word_done ? {rx_field[`SFC_POS_M1 - 20],
			rx_field[`SFC_POS_M0 - 20]} : sb_last_reg; // RQ19
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			slot_reg <= '0;
			sb_last_reg <= '0;
			vote0_reg <= '0;
			vote1_reg <= '0;
			ind_cnt_reg <= '{default: '0};
			ind_reg <= '0;
		end else begin
			if (sb_step) begin
				slot_reg <= slot_reg + 4'd1; // RQ19
				sb_last_reg <= sb_now;
				if (slot_reg[1:0] == 2'h0)
					vote0_reg <= sb_now;
				if (slot_reg[1:0] == 2'h1)
					vote1_reg <= sb_now;
			end
			for (int ch = 0; ch < 2; ch++) begin
				if (is_fill) begin
					ind_cnt_reg[ch] <= '0; // RQ17
					ind_reg[ch] <= 1'b0;
				end else if (sb_step && slot_reg[1:0] == `SFC_SB_LANE_VOTE &&
					maj3(vote0_reg[ch], vote1_reg[ch], sb_now[ch])) begin
					ind_cnt_reg[ch] <= 4'(IND_CYC - 1); // RQ23
					ind_reg[ch] <= 1'b1;
				end else if (ind_cnt_reg[ch] != 4'h0) begin
					ind_cnt_reg[ch] <= ind_cnt_reg[ch] - 4'h1;
				end else begin
					ind_reg[ch] <= 1'b0;
				end
			end
		end
	end
	assign ready_o = ind_reg[0];
	assign connect_o = ind_reg[1];

	// Checks
	property p_tx_square;
		@(posedge clk_i) disable iff (!resetn_i)
		ctrl_reg[`SFC_CTRL_SQUARE] |=>
			tx_frame_o == {`SFC_NIB_FILL, `SFC_FIELD_SQUARE};
	endproperty
	a_tx_square: assert property (p_tx_square) else $error("no square fill"); // RQ7

	property p_bal_reinit;
		@(posedge clk_i) disable iff (!resetn_i)
		$fell(ctrl_reg[`SFC_CTRL_SQUARE]) |=>
			bal_reg == BAL_W'(frame_disp(tx_frame_o));
	endproperty
	a_bal_reinit: assert property (p_bal_reinit) else $error("no restart"); // RQ3

	property p_bal_track;
		@(posedge clk_i) disable iff (!resetn_i)
		##1 1'b1 |-> bal_reg == tx_base_reg + BAL_W'(frame_disp(tx_frame_o));
	endproperty
	a_bal_track: assert property (p_bal_track) else $error("bad balance"); // RQ2

	property p_inv;
		@(posedge clk_i) disable iff (!resetn_i)
		(tx_frame_o[23:20] != `SFC_NIB_FILL) |->
			((tx_base_reg >= 0) ? (frame_disp(tx_frame_o) <= 0) :
			(frame_disp(tx_frame_o) >= 0));
	endproperty
	a_inv: assert property (p_inv) else $error("wrong inversion"); // RQ6

	property p_ready_fill;
		@(posedge clk_i) disable iff (!resetn_i)
		ctrl_reg[`SFC_CTRL_READY] && !ctrl_reg[`SFC_CTRL_SQUARE] |=>
			tx_frame_o[19:0] == ((tx_base_reg > 0) ? `SFC_FIELD_LIGHT :
			`SFC_FIELD_HEAVY);
	endproperty
	a_ready_fill: assert property (p_ready_fill) else $error("bad fill"); // RQ8

	property p_one_seen;
		@(posedge clk_i) disable iff (!resetn_i)
		rx_valid_i && rx_kind != SFC_K_RESERVED |=> $onehot(seen_reg);
	endproperty
	a_one_seen: assert property (p_one_seen) else $error("seen not one"); // RQ13

	property p_fill_zero;
		@(posedge clk_i) disable iff (!resetn_i)
		square_fill_seen_o || ready_fill_seen_o |->
			dst_o == '0 && dst_valid_o ##1 !ready_o && !connect_o;
	endproperty
	a_fill_zero: assert property (p_fill_zero) else $error("fill leak"); // RQ17

	property p_err_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		frame_error_seen_o |-> dst_o.parity == '0 &&
			dst_o.request == $past(dst_o.request) &&
			dst_o.packet == $past(dst_o.packet) &&
			dst_o.burst == $past(dst_o.burst);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error no hold"); // RQ18

	// Error run rebuilt from the flags; reserved frames leave it alone
	logic chk_err_reg;
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			chk_err_reg <= 1'b0;
		else if (frame_error_seen_o)
			chk_err_reg <= 1'b1;
		else if (data_frame_seen_o || square_fill_seen_o ||
			ready_fill_seen_o)
			chk_err_reg <= 1'b0;
	end

	property p_reset;
		@(posedge clk_i) disable iff (!resetn_i)
		link_reset_o == (frame_error_seen_o && chk_err_reg);
	endproperty
	a_reset: assert property (p_reset) else $error("no link reset"); // RQ20

	// Length of the current ready pulse, saturating
	logic [3:0] chk_run_reg;
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			chk_run_reg <= '0;
		else if (ready_o)
			chk_run_reg <= (chk_run_reg == 4'hF) ? 4'hF : chk_run_reg + 4'h1;
		else
			chk_run_reg <= '0;
	end

	// A pulse ends early only when a fill frame cuts it
	property p_ind;
		@(posedge clk_i) disable iff (!resetn_i)
		$fell(ready_o) |-> $past(is_fill) || chk_run_reg >= 4'(IND_CYC);
	endproperty
	a_ind: assert property (p_ind) else $error("ready too short"); // RQ23

	c_word: cover property (@(posedge clk_i) disable iff (!resetn_i)
		word_done);
	c_reset: cover property (@(posedge clk_i) disable iff (!resetn_i)
		link_reset_o);
	c_ready: cover property (@(posedge clk_i) disable iff (!resetn_i)
		$rose(ready_o));

endmodule

// ==== verification/sfc_far_end.sv ====
// Far-end link model: echoes frames back, may stall or insert errors
`timescale 1ns/100ps
`include "sfc_params.svh"

module sfc_far_end (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [23:0] tx_frame_i,
	input wire logic stall_i,
	input wire logic err_arm_i,
	output logic [23:0] rx_bits_o,
	output logic rx_valid_o
);
	logic [23:0] q[$];
	logic [23:0] f;
	int err_left;
	bit used;

	// Backlog grows while stalled; later frames arrive late, never lost
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			q.delete();
			err_left = 0;
			used = 1'b0;
			rx_valid_o <= 1'b0;
			rx_bits_o <= 24'h0;
		end else begin
			q.push_back(tx_frame_i);
			if (err_left > 0) begin
				rx_bits_o <= {`SFC_NIB_ALT_A, 20'h5A5A5};
				rx_valid_o <= 1'b1;
				err_left = err_left - 1;
			end else if (stall_i || q.size() == 0) begin
				rx_bits_o <= ~rx_bits_o;
				rx_valid_o <= 1'b0;
			end else begin
				f = q.pop_front();
				rx_bits_o <= f;
				rx_valid_o <= 1'b1;
				// Errors follow a completed word so control stays held
				if (err_arm_i && !used && (f[23:20] == `SFC_NIB_D1_TRUE ||
					f[23:20] == `SFC_NIB_D1_INV)) begin
					err_left = 2;
					used = 1'b1;
				end
			end
			if (!err_arm_i) used = 1'b0;
		end
	end
endmodule

// ==== verification/sfc_codec_tb_top.sv ====
// Self-checking bench for the serial frame codec
`timescale 1ns/100ps
`include "sfc_params.svh"

module sfc_codec_tb_top;
	import sfc_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [`SFC_ADDR_W-1:0] reg_addr_i = '0;
	logic [31:0] reg_wdata_i = '0;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic [31:0] reg_rdata_o;
	sfc_word_t tx_word_i = '0;
	logic tx_valid_i = 1'b0;
	logic tx_ready_o;
	logic unlocked = 1'b0;
	logic [23:0] tx_frame_o;
	logic [23:0] rx_bits_i;
	logic rx_valid_i;
	logic dfs, sfs, rfs, fes, link_reset, dst_valid, ready_o, connect_o;
	sfc_dst_t dst_o;
	logic stall = 1'b0;
	logic stall_en = 1'b0;
	logic err_arm = 1'b0;
	logic [2:0] last_ctl = 3'h0;
	logic [38:0] got_q[$];
	logic [38:0] exp_q[$];
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int errs = 0;
	int resets = 0;
	int n_sq = 0;
	int n_rf = 0;
	bit rdy_seen = 0;
	bit con_seen = 0;

	sfc_codec #(.BAL_W(8)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.tx_word_i(tx_word_i), .tx_valid_i(tx_valid_i),
		.tx_ready_o(tx_ready_o), .tx_multiplier_unlocked_i(unlocked),
		.tx_frame_o(tx_frame_o), .rx_bits_i(rx_bits_i),
		.rx_valid_i(rx_valid_i), .data_frame_seen_o(dfs),
		.square_fill_seen_o(sfs), .ready_fill_seen_o(rfs),
		.frame_error_seen_o(fes), .link_reset_o(link_reset), .dst_o(dst_o),
		.dst_valid_o(dst_valid), .ready_o(ready_o), .connect_o(connect_o));

	sfc_far_end u_far (.clk_i(clk_i), .resetn_i(resetn_i),
		.tx_frame_i(tx_frame_o), .stall_i(stall), .err_arm_i(err_arm),
		.rx_bits_o(rx_bits_i), .rx_valid_o(rx_valid_i));

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
	endtask

	// Invalid control combinations travel as idle
	function automatic logic [2:0] fix(input logic [2:0] c);
		if (c == 3'h4 || c == 3'h6 || c == 3'h7) return c;
		return 3'h0;
	endfunction

	function automatic sfc_word_t rnd_word(input logic [2:0] c, input bit sb);
		sfc_word_t w;
		w.data = $urandom();
		w.parity = 4'($urandom());
		{w.request, w.packet, w.burst} = c;
		w.sideband_bit_zero = sb;
		w.sideband_bit_one = sb;
		return w;
	endfunction

	task automatic send_word(input sfc_word_t w);
		@(posedge clk_i);
		tx_word_i <= w;
		tx_valid_i <= 1'b1;
		@(negedge clk_i);
		while (tx_ready_o !== 1'b1) @(negedge clk_i);
		@(posedge clk_i);
		tx_valid_i <= 1'b0;
		exp_q.push_back({w.data, w.parity,
			fix({w.request, w.packet, w.burst})});
	endtask

	task automatic cmp_words();
		check("word_count", exp_q.size(), got_q.size());
		while (exp_q.size() > 0 && got_q.size() > 0) begin
			check("word", exp_q.pop_front(), got_q.pop_front());
		end
	endtask

	always @(posedge clk_i) begin
		stall <= stall_en && ($urandom_range(7) == 0);
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			$display("mismatch timeout expected done seen hang");
			summarize();
		end
	end

	always @(negedge clk_i) begin
		if (resetn_i) begin
			check("onehot", 1, $countones({dfs, sfs, rfs, fes}) <= 1);
			check("tx_nib", 1, tx_frame_o[23:20] inside {4'hB, 4'h4, 4'hD,
				4'h2, 4'hC});
			if (dfs && dst_valid) begin
				got_q.push_back(dst_o);
				last_ctl = {dst_o.request, dst_o.packet, dst_o.burst};
			end
			if (sfs || rfs) check("fill_dst", 39'h0, dst_o);
			if (fes) check("err_dst", {36'h0, last_ctl}, dst_o);
			n_sq += sfs;
			n_rf += rfs;
			errs += fes;
			resets += link_reset;
			rdy_seen |= (ready_o === 1'b1);
			con_seen |= (connect_o === 1'b1);
		end
	end

	initial begin
		logic [31:0] rd;
		logic [23:0] prev;
		void'($urandom(32'hCC594045));
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		check("rst_frame", {`SFC_NIB_FILL, `SFC_FIELD_SQUARE}, tx_frame_o);
		check("rst_ready", 1'b0, tx_ready_o);
		@(posedge clk_i);
		resetn_i <= 1'b1;
		unlocked <= 1'b1;
		reg_rd(`SFC_ADDR_STATUS, rd);
		check("unlock", 1'b1, rd[`SFC_ST_UNLOCK]);
		reg_rd(4'hC, rd);
		check("unmapped", 32'h0, rd);
		reg_wr(`SFC_ADDR_CTRL, 32'h1);
		reg_rd(`SFC_ADDR_CTRL, rd);
		check("ctrl", 32'h1, rd);
		stall_en <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			send_word(rnd_word(i < 8 ? 3'(i) : 3'($urandom()), 1'b0));
		end
		stall_en <= 1'b0;
		repeat (120) @(negedge clk_i);
		cmp_words();
		check("no_ready", 1'b0, rdy_seen | con_seen);
		reg_rd(`SFC_ADDR_BALANCE, rd);
		check("bal_rng", 1, $signed(rd[7:0]) inside {[-31:31]});
		for (int i = 0; i < 24; i++) begin
			send_word(rnd_word(3'($urandom()), 1'b1));
		end
		repeat (100) @(negedge clk_i);
		cmp_words();
		check("sideband", 2'h3, {rdy_seen, con_seen});
		err_arm <= 1'b1;
		send_word(rnd_word(3'h6, 1'b0));
		repeat (100) @(negedge clk_i);
		err_arm <= 1'b0;
		cmp_words();
		check("errs", 2, errs);
		check("resets", 1, resets);
		reg_wr(`SFC_ADDR_CTRL, 32'h2);
		repeat (4) @(negedge clk_i);
		repeat (8) begin
			@(negedge clk_i);
			check("square", {`SFC_NIB_FILL, `SFC_FIELD_SQUARE}, tx_frame_o);
		end
		reg_wr(`SFC_ADDR_CTRL, 32'h4);
		repeat (3) @(negedge clk_i);
		prev = tx_frame_o;
		repeat (10) begin
			@(negedge clk_i);
			check("ready_alt", 1, tx_frame_o != prev && (tx_frame_o ==
				{`SFC_NIB_FILL, `SFC_FIELD_HEAVY} || tx_frame_o ==
				{`SFC_NIB_FILL, `SFC_FIELD_LIGHT}));
			prev = tx_frame_o;
		end
		reg_rd(`SFC_ADDR_BALANCE, rd);
		check("bal_restart", 1, rd == 32'h0 || rd == 32'h2);
		repeat (80) @(negedge clk_i);
		check("fills_seen", 1, n_sq > 0 && n_rf > 0);
		summarize();
	end
endmodule
